//--- transceiver_defs.svh
// Register offsets, field positions and reset values of the bus transceiver
`ifndef TRANSCEIVER_DEFS_SVH
`define TRANSCEIVER_DEFS_SVH

// Byte offsets on the register bus
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define LOG_OFFSET 8'h08
`define PINS_OFFSET 8'h0c

// Control register fields
`define CTRL_LOG_ENABLE_BIT 0
`define CTRL_FORCE_ISOLATE_BIT 1
`define CTRL_RESET_VALUE 2'h0

// Status register fields
`define STATUS_A_STORE_LSB 0
`define STATUS_B_STORE_LSB 8
`define STATUS_EMPTY_BIT 16
`define STATUS_FULL_BIT 17
`define STATUS_OVERFLOW_BIT 18

// Capture log entry fields
`define LOG_A_DATA_LSB 0
`define LOG_B_DATA_LSB 8
`define LOG_A_CAPTURED_BIT 16
`define LOG_B_CAPTURED_BIT 17
`define LOG_VALID_BIT 31

// Pin level register fields
`define PINS_A_TO_B_SELECT_BIT 0
`define PINS_B_TO_A_SELECT_BIT 1
`define PINS_B_DRIVE_BIT 2
`define PINS_A_DRIVE_N_BIT 3
`define PINS_A_OE_BIT 4
`define PINS_B_OE_BIT 5

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- transceiver_pkg.sv
// Types shared by the bus transceiver modules
package transceiver_pkg;
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_APPLY = 2'b01,
    WR_RESP = 2'b10
  } write_state_e;

  typedef enum logic [0:0] {
    RD_ADDR = 1'b0,
    RD_DATA = 1'b1
  } read_state_e;

  // One log entry: both bus bytes sampled at the edge and which of them were captured
  typedef struct packed {
    logic b_captured;
    logic a_captured;
    logic [7:0] b_data;
    logic [7:0] a_data;
  } log_entry_s;
endpackage

//--- capture_stream_if.sv
// Valid/ready stream carrying capture log entries between modules
interface capture_stream_if #(parameter int WIDTH = 18) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface

//--- port_store.sv
// Edge-triggered storage register for one bus side
module port_store #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] bus_in,
  input wire logic store_clock,
  output logic [WIDTH-1:0] stored,
  output logic captured
);
  logic clock_prev;

  // Previous clock level; high in reset so no edge is seen at release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_prev <= 1'b1;
    end else begin
      clock_prev <= store_clock;
    end
  end

  assign captured = store_clock & ~clock_prev;

  // Capture on every rising edge, never gated, never reset
  always_ff @(posedge aclk) begin
    if (captured) begin
      stored <= bus_in;
    end
  end
endmodule

//--- capture_fifo.sv
// Capture log FIFO with valid and ready on both sides
module capture_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  capture_stream_if.sink fill,
  capture_stream_if.source drain
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  // Wrap bit differs and index equal means full
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign fill.ready = !full;
  assign drain.valid = !empty;
  assign drain.data = mem[rd_ptr[AW-1:0]];

  // Storage array
  always_ff @(posedge aclk) begin
    if (fill.valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= fill.data;
    end
  end

  // Pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (fill.valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (drain.ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

//--- registered_bus_transceiver.sv
// Registered octal bus transceiver with capture log and register slave
// Behaviour
// - Two 8-bit two-way ports, A and B
// - Separate clocks load A and B registers
// - Every rising clock edge captures bus pins
// - High enable drives B, low enable drives A
// - Select picks stored or live data
// - Both ports input when neither drives
// - Driven data keeps source polarity
// - Select low live, select high stored
// - Both selects high swap stored bytes
// - Driven B loops A into both registers
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`include "transceiver_defs.svh"

module registered_bus_transceiver
  import transceiver_pkg::*;
#(
  parameter int BUS_WIDTH = 8,
  parameter int ADDR_WIDTH = 8,
  parameter int LOG_DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic a_to_b_clock,
  input wire logic b_to_a_clock,
  input wire logic a_to_b_source_select,
  input wire logic b_to_a_source_select,
  input wire logic b_port_drive_enable,
  input wire logic a_port_drive_enable_n,
  input wire logic [BUS_WIDTH-1:0] a_in,
  output logic [BUS_WIDTH-1:0] a_out,
  output logic a_oe,
  input wire logic [BUS_WIDTH-1:0] b_in,
  output logic [BUS_WIDTH-1:0] b_out,
  output logic b_oe,
  output logic capture_log_ready
);
  localparam int LOG_WIDTH = $bits(log_entry_s);
  localparam logic [1:0] CTRL_INIT = `CTRL_RESET_VALUE;

  // Side 0 is A, side 1 is B
  logic [BUS_WIDTH-1:0] side_bus [2];
  logic side_clock [2];
  logic [BUS_WIDTH-1:0] side_stored [2];
  logic side_captured [2];

  // Control and status state
  logic log_enable;
  logic force_isolate;
  logic overflow;
  logic overflow_clear;

  // Write channel state
  write_state_e wr_state;
  logic aw_held;
  logic w_held;
  logic [ADDR_WIDTH-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_take;
  logic w_take;
  logic wr_apply;

  // Read channel state
  read_state_e rd_state;
  logic ar_take;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Output path next values
  logic [BUS_WIDTH-1:0] next_a_out;
  logic [BUS_WIDTH-1:0] next_b_out;
  logic next_a_oe;
  logic next_b_oe;

  log_entry_s push_entry;
  log_entry_s head_entry;

  capture_stream_if #(.WIDTH(LOG_WIDTH)) log_in ();
  capture_stream_if #(.WIDTH(LOG_WIDTH)) log_out ();

  // True when an address falls in the word of a given offset
  function automatic logic addr_hits(input logic [ADDR_WIDTH-1:0] addr,
                                     input logic [7:0] offset);
    logic [ADDR_WIDTH-1:0] wide;
    wide = ADDR_WIDTH'(offset);
    return addr[ADDR_WIDTH-1:2] == wide[ADDR_WIDTH-1:2];
  endfunction

  // True when an address names any register of the block
  function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] addr);
    return addr_hits(addr, `CTRL_OFFSET) || addr_hits(addr, `STATUS_OFFSET) ||
           addr_hits(addr, `LOG_OFFSET) || addr_hits(addr, `PINS_OFFSET);
  endfunction

  // Pins feed the two storage registers
  assign side_bus[0] = a_in;
  assign side_bus[1] = b_in;
  assign side_clock[0] = a_to_b_clock;
  assign side_clock[1] = b_to_a_clock;

  // One storage register per side, each on its own clock pin
  generate
    for (genvar g = 0; g < 2; g++) begin : g_store
      port_store #(.WIDTH(BUS_WIDTH)) u_store (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus_in(side_bus[g]),
        .store_clock(side_clock[g]),
        .stored(side_stored[g]),
        .captured(side_captured[g])
      );
    end
  endgenerate

  // Source selection: live opposite bus or stored byte, never inverted
  always_comb begin
    next_b_out = a_to_b_source_select ? side_stored[0] : a_in;
    next_a_out = b_to_a_source_select ? side_stored[1] : b_in;
  end

  // Direction from the two enables; software may force isolation
  always_comb begin
    next_b_oe = b_port_drive_enable && !force_isolate;
    next_a_oe = !a_port_drive_enable_n && !force_isolate;
  end

  // Port data registers; both drive at once when both enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_out <= '0;
      b_out <= '0;
    end else begin
      a_out <= next_a_out;
      b_out <= next_b_out;
    end
  end

  // Port enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_oe <= 1'b0;
      b_oe <= 1'b0;
    end else begin
      a_oe <= next_a_oe;
      b_oe <= next_b_oe;
    end
  end

  // Log every capture edge while logging is enabled and the log is not full, both sides in one entry
  always_comb begin
    push_entry.a_data = side_bus[0];
    push_entry.b_data = side_bus[1];
    push_entry.a_captured = side_captured[0];
    push_entry.b_captured = side_captured[1];
  end

  assign log_in.valid = log_enable && (side_captured[0] || side_captured[1]);
  assign log_in.data = push_entry;

  capture_fifo #(.WIDTH(LOG_WIDTH), .DEPTH(LOG_DEPTH)) u_log (
    .aclk(aclk),
    .aresetn(aresetn),
    .fill(log_in.sink),
    .drain(log_out.source)
  );

  assign head_entry = log_out.data;
  // Reading the log register pops one entry
  assign log_out.ready = ar_take && addr_hits(araddr, `LOG_OFFSET);

  // Registered copy of the log's ready for the outside
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_log_ready <= 1'b0;
    end else begin
      capture_log_ready <= log_in.ready;
    end
  end

  // Sticky overflow: a lost entry wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow <= 1'b0;
    end else if (log_in.valid && !log_in.ready) begin
      overflow <= 1'b1;
    end else if (overflow_clear) begin
      overflow <= 1'b0;
    end
  end

  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign wr_apply = (wr_state == WR_APPLY);
  assign overflow_clear = wr_apply && addr_hits(wr_addr, `STATUS_OFFSET) &&
                          wr_strb[2] && wr_data[`STATUS_OVERFLOW_BIT];

  // Write channel: collect address and data in any order, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_COLLECT;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      case (wr_state)
        WR_COLLECT: begin
          if (aw_take) begin
            wr_addr <= awaddr;
            aw_held <= 1'b1;
          end
          if (w_take) begin
            wr_data <= wdata;
            wr_strb <= wstrb;
            w_held <= 1'b1;
          end
          if ((aw_held || aw_take) && (w_held || w_take)) begin
            awready <= 1'b0;
            wready <= 1'b0;
            wr_state <= WR_APPLY;
          end else begin
            awready <= !(aw_held || aw_take);
            wready <= !(w_held || w_take);
          end
        end
        WR_APPLY: begin
          bvalid <= 1'b1;
          bresp <= addr_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
          wr_state <= WR_RESP;
        end
        WR_RESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            wr_state <= WR_COLLECT;
          end
        end
        default: begin
          wr_state <= WR_COLLECT;
        end
      endcase
    end
  end

  // Control register, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_enable <= CTRL_INIT[`CTRL_LOG_ENABLE_BIT];
      force_isolate <= CTRL_INIT[`CTRL_FORCE_ISOLATE_BIT];
    end else if (wr_apply && addr_hits(wr_addr, `CTRL_OFFSET) && wr_strb[0]) begin
      log_enable <= wr_data[`CTRL_LOG_ENABLE_BIT];
      force_isolate <= wr_data[`CTRL_FORCE_ISOLATE_BIT];
    end
  end

  // Read data for the address on the read channel
  always_comb begin
    next_rdata = 32'h0;
    next_rresp = `RESP_OKAY;
    if (addr_hits(araddr, `CTRL_OFFSET)) begin
      next_rdata[`CTRL_LOG_ENABLE_BIT] = log_enable;
      next_rdata[`CTRL_FORCE_ISOLATE_BIT] = force_isolate;
    end else if (addr_hits(araddr, `STATUS_OFFSET)) begin
      next_rdata[`STATUS_A_STORE_LSB +: 8] = side_stored[0];
      next_rdata[`STATUS_B_STORE_LSB +: 8] = side_stored[1];
      next_rdata[`STATUS_EMPTY_BIT] = !log_out.valid;
      next_rdata[`STATUS_FULL_BIT] = !log_in.ready;
      next_rdata[`STATUS_OVERFLOW_BIT] = overflow;
    end else if (addr_hits(araddr, `LOG_OFFSET)) begin
      if (log_out.valid) begin
        next_rdata[`LOG_A_DATA_LSB +: 8] = head_entry.a_data;
        next_rdata[`LOG_B_DATA_LSB +: 8] = head_entry.b_data;
        next_rdata[`LOG_A_CAPTURED_BIT] = head_entry.a_captured;
        next_rdata[`LOG_B_CAPTURED_BIT] = head_entry.b_captured;
        next_rdata[`LOG_VALID_BIT] = 1'b1;
      end
    end else if (addr_hits(araddr, `PINS_OFFSET)) begin
      next_rdata[`PINS_A_TO_B_SELECT_BIT] = a_to_b_source_select;
      next_rdata[`PINS_B_TO_A_SELECT_BIT] = b_to_a_source_select;
      next_rdata[`PINS_B_DRIVE_BIT] = b_port_drive_enable;
      next_rdata[`PINS_A_DRIVE_N_BIT] = a_port_drive_enable_n;
      next_rdata[`PINS_A_OE_BIT] = a_oe;
      next_rdata[`PINS_B_OE_BIT] = b_oe;
    end else begin
      next_rresp = `RESP_SLVERR;
    end
  end

  assign ar_take = arvalid && arready;

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_ADDR;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else begin
      case (rd_state)
        RD_ADDR: begin
          if (ar_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
            rd_state <= RD_DATA;
          end else begin
            arready <= 1'b1;
          end
        end
        RD_DATA: begin
          if (rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
            rd_state <= RD_ADDR;
          end
        end
        default: begin
          rd_state <= RD_ADDR;
        end
      endcase
    end
  end
endmodule

//--- transceiver_asserts.sv
// Pin side assertions for the registered bus transceiver
module transceiver_asserts #(
  parameter int BUS_WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic a_to_b_clock,
  input wire logic b_to_a_clock,
  input wire logic a_to_b_source_select,
  input wire logic b_to_a_source_select,
  input wire logic b_port_drive_enable,
  input wire logic a_port_drive_enable_n,
  input wire logic [BUS_WIDTH-1:0] a_in,
  input wire logic [BUS_WIDTH-1:0] a_out,
  input wire logic a_oe,
  input wire logic [BUS_WIDTH-1:0] b_in,
  input wire logic [BUS_WIDTH-1:0] b_out,
  input wire logic b_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ab_prev;
  logic ba_prev;
  logic a_held;
  logic b_held;
  logic [BUS_WIDTH-1:0] a_copy;
  logic [BUS_WIDTH-1:0] b_copy;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Clock pin history, held high in reset
  always_ff @(posedge aclk) begin
    ab_prev <= aresetn ? a_to_b_clock : 1'b1;
    ba_prev <= aresetn ? b_to_a_clock : 1'b1;
  end
  // Reference copies of both stores
  always_ff @(posedge aclk) begin
    if (aresetn && a_to_b_clock && !ab_prev) a_copy <= a_in;
    if (aresetn && b_to_a_clock && !ba_prev) b_copy <= b_in;
  end
  // Copies valid once loaded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_held <= 1'b0;
      b_held <= 1'b0;
    end else begin
      a_held <= a_held | (a_to_b_clock & ~ab_prev);
      b_held <= b_held | (b_to_a_clock & ~ba_prev);
    end
  end
  property p_a_dir;
    a_oe |-> $past(!a_port_drive_enable_n);
  endproperty
  a_a_dir: assert property (p_a_dir) else $error("a port driven without enable");
  property p_b_dir;
    b_oe |-> $past(b_port_drive_enable);
  endproperty
  a_b_dir: assert property (p_b_dir) else $error("b port driven without enable");
  property p_isolate;
    $past(!b_port_drive_enable && a_port_drive_enable_n) |-> !a_oe && !b_oe;
  endproperty
  a_isolate: assert property (p_isolate) else $error("port driven in isolation");
  property p_b_live;
    b_oe && $past(!a_to_b_source_select) |-> b_out == $past(a_in);
  endproperty
  a_b_live: assert property (p_b_live) else $error("b port live data wrong");
  property p_a_live;
    a_oe && $past(!b_to_a_source_select) |-> a_out == $past(b_in);
  endproperty
  a_a_live: assert property (p_a_live) else $error("a port live data wrong");
  property p_b_stored;
    b_oe && $past(a_to_b_source_select && a_held) |-> b_out == $past(a_copy);
  endproperty
  a_b_stored: assert property (p_b_stored) else $error("b port stored data wrong");
  property p_a_stored;
    a_oe && $past(b_to_a_source_select && b_held) |-> a_out == $past(b_copy);
  endproperty
  a_a_stored: assert property (p_a_stored) else $error("a port stored data wrong");
  property p_both;
    $past(b_port_drive_enable && !a_port_drive_enable_n) |-> a_oe == b_oe;
  endproperty
  a_both: assert property (p_both) else $error("ports not driven together");
endmodule

bind registered_bus_transceiver transceiver_asserts #(.BUS_WIDTH(BUS_WIDTH)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .a_to_b_clock(a_to_b_clock), .b_to_a_clock(b_to_a_clock),
  .a_to_b_source_select(a_to_b_source_select), .b_to_a_source_select(b_to_a_source_select),
  .b_port_drive_enable(b_port_drive_enable), .a_port_drive_enable_n(a_port_drive_enable_n),
  .a_in(a_in), .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe));

//--- bus_partner.sv
// Behavioural model of the A and B buses facing the transceiver
module bus_partner (
  input wire logic aclk,
  input wire logic [7:0] a_out,
  input wire logic a_oe,
  input wire logic [7:0] b_out,
  input wire logic b_oe,
  input wire logic [7:0] a_drv,
  input wire logic a_drv_en,
  input wire logic [7:0] b_drv,
  input wire logic b_drv_en,
  output logic [7:0] a_bus,
  output logic [7:0] b_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] a_last = 8'h00;
  logic [7:0] b_last = 8'h00;
  // Released lines show the inverse of their last driven level
  always_ff @(posedge aclk) begin
    if (a_oe || a_drv_en) a_last <= a_bus;
    if (b_oe || b_drv_en) b_last <= b_bus;
  end
  // Wire level: device drive, then far side, then floating
  assign a_bus = a_oe ? a_out : (a_drv_en ? a_drv : ~a_last);
  assign b_bus = b_oe ? b_out : (b_drv_en ? b_drv : ~b_last);
endmodule

//--- registered_bus_transceiver_tb.sv
// Self-checking bench for the registered bus transceiver
`include "transceiver_defs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected at %0t got %h expected %h", $time, got, exp); end end

module registered_bus_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, log_ready;
  logic ab_clk, ba_clk, ab_sel, ba_sel, b_en, a_en_n, a_oe, b_oe, a_drv_en, b_drv_en;
  logic [7:0] awaddr, araddr, a_in, a_out, b_in, b_out, a_drv, b_drv;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0] bresp, rresp, rs;
  int failures = 0;
  int checks_done = 0;

  registered_bus_transceiver dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .a_to_b_clock(ab_clk),
    .b_to_a_clock(ba_clk), .a_to_b_source_select(ab_sel), .b_to_a_source_select(ba_sel),
    .b_port_drive_enable(b_en), .a_port_drive_enable_n(a_en_n), .a_in(a_in), .a_out(a_out),
    .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe), .capture_log_ready(log_ready));

  bus_partner bus_u (.aclk(aclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .a_drv(a_drv), .a_drv_en(a_drv_en), .b_drv(b_drv), .b_drv_en(b_drv_en),
    .a_bus(a_in), .b_bus(b_in));

  // Free running clock
  always #50 aclk = ~aclk;

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    r = 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (n == 40) begin
      failures++;
      print_verdict;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    {d, r} = {32'h0, 2'h3};
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        {d, r} = {rdata, rresp};
        break;
      end
    end
    rready <= 1'b0;
    if (n == 40) begin
      failures++;
      print_verdict;
    end
  endtask

  // Pin levels: drive enables and selects, then far side bytes with their enables
  task automatic set(input logic [3:0] p, input logic [8:0] a, input logic [8:0] b);
    @(posedge aclk);
    {b_en, a_en_n, ab_sel, ba_sel} <= p;
    {a_drv_en, a_drv, b_drv_en, b_drv} <= {a, b};
    repeat (3) @(posedge aclk);
  endtask

  task automatic pulse(input logic ab, input logic ba);
    @(posedge aclk);
    {ab_clk, ba_clk} <= {ab, ba};
    @(posedge aclk);
    {ab_clk, ba_clk} <= 2'b00;
    @(posedge aclk);
  endtask

  task automatic t_regs;
    rd(`CTRL_OFFSET, rd_v, rs);
    `CHK(rd_v, 32'h0)
    rd(8'h10, rd_v, rs);
    `CHK(rs, `RESP_SLVERR)
    wr(8'h10, 32'h1, rs);
    `CHK(rs, `RESP_SLVERR)
    wstrb <= 4'he;
    wr(`CTRL_OFFSET, 32'h3, rs);
    wstrb <= 4'hf;
    rd(`CTRL_OFFSET, rd_v, rs);
    `CHK(rd_v, 32'h0)
    $display("t_regs done");
  endtask

  task automatic t_iso;
    set(4'b0100, 9'h15a, 9'h1a5);
    pulse(1'b1, 1'b1);
    `CHK({a_oe, b_oe}, 2'b00)
    rd(`STATUS_OFFSET, rd_v, rs);
    `CHK(rd_v[15:0], 16'ha55a)
    set(4'b0100, 9'h111, 9'h1a5);
    pulse(1'b1, 1'b0);
    rd(`STATUS_OFFSET, rd_v, rs);
    `CHK(rd_v[15:0], 16'ha511)
    $display("t_iso done");
  endtask

  task automatic t_live;
    set(4'b1100, 9'h13c, 9'h000);
    `CHK({a_oe, b_oe, b_out}, 10'h13c)
    set(4'b1100, 9'h1c3, 9'h000);
    `CHK(b_out, 8'hc3)
    set(4'b0000, 9'h000, 9'h196);
    `CHK({a_oe, b_oe, a_out}, 10'h296)
    rd(`PINS_OFFSET, rd_v, rs);
    `CHK(rd_v, 32'h10)
    $display("t_live done");
  endtask

  task automatic t_stored;
    set(4'b0100, 9'h112, 9'h000);
    pulse(1'b1, 1'b0);
    set(4'b0100, 9'h000, 9'h134);
    pulse(1'b0, 1'b1);
    set(4'b1011, 9'h000, 9'h000);
    `CHK({a_oe, b_oe, a_out, b_out}, 18'h33412)
    wr(`CTRL_OFFSET, 32'h2, rs);
    @(posedge aclk);
    `CHK({a_oe, b_oe}, 2'b00)
    wr(`CTRL_OFFSET, 32'h0, rs);
    set(4'b1010, 9'h000, 9'h000);
    `CHK({b_oe, b_out}, 9'h112)
    $display("t_stored done");
  endtask

  task automatic t_loop;
    set(4'b1100, 9'h177, 9'h000);
    pulse(1'b1, 1'b1);
    rd(`STATUS_OFFSET, rd_v, rs);
    `CHK(rd_v[15:0], 16'h7777)
    $display("t_loop done");
  endtask

  task automatic t_fifo;
    wr(`CTRL_OFFSET, 32'h1, rs);
    `CHK(rs, `RESP_OKAY)
    set(4'b0100, 9'h140, 9'h000);
    repeat (33) pulse(1'b1, 1'b0);
    `CHK(log_ready, 1'b0)
    rd(`STATUS_OFFSET, rd_v, rs);
    `CHK(rd_v[18:16], 3'b110)
    repeat (32) begin
      rd(`LOG_OFFSET, rd_v, rs);
      `CHK({rd_v[31], rd_v[17:16], rd_v[7:0]}, 11'h540)
    end
    rd(`LOG_OFFSET, rd_v, rs);
    `CHK(rd_v, 32'h0)
    rd(`STATUS_OFFSET, rd_v, rs);
    `CHK({log_ready, rd_v[16]}, 2'b11)
    wr(`STATUS_OFFSET, 32'h40000, rs);
    rd(`STATUS_OFFSET, rd_v, rs);
    `CHK(rd_v[18], 1'b0)
    $display("t_fifo done");
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Reset, then every scenario in turn
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {ab_clk, ba_clk, ab_sel, ba_sel, b_en, a_en_n, a_drv_en, b_drv_en} = 8'h04;
    {awaddr, araddr, wdata, a_drv, b_drv} = 64'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_iso;
    t_live;
    t_stored;
    t_loop;
    t_fifo;
    print_verdict;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict;
  end
endmodule
